// [rtl/mdpc_top.sv]
// Delay parameter control: MIDI control-change decoding, panel/MIDI arbitration, lamps.
// Assumes panel values and lamp events come from logic on sys_clk; midi_in is a raw pin.
`timescale 1ns/1ps
`include "mdpc_defs.svh"

module mdpc_top
  import mdpc_pkg::*;
#(
  parameter int BIT_CYC = `MDPC_BIT_CYC,
  parameter int TICK_CYC = `MDPC_TICK_CYC,
  parameter int FLASH_TICKS = `MDPC_FLASH_TICKS
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic midi_in,
  input wire logic [3:0] midi_chan,
  input wire logic [13:0] panel_time,
  input wire logic [13:0] panel_feedback,
  input wire logic panel_span_long,
  input wire logic tap_to_time,
  input wire logic tap_to_rate,
  input wire logic tap_beat,
  input wire logic mod_wave_level,
  input wire logic mod_sync,
  input wire logic sig_present,
  input wire logic limit_start,
  input wire logic clipping,
  input wire logic engaged,
  output logic tempo_lock_switch,
  output logic span_select,
  output logic [13:0] feedback,
  output logic [13:0] glide_speed,
  output logic [6:0] length_extender,
  output logic [2:0] beat_fraction,
  output logic tone_dark,
  output logic [19:0] delay_time,
  output logic time_illegal,
  output mdpc_lamp_t echo_length_lamp,
  output mdpc_lamp_t modulator_lamp,
  output mdpc_lamp_t signal_meter_lamp,
  output logic message_lamp,
  output logic engage_switch_lamp
);

  if (TICK_CYC < 1 || TICK_CYC > 65535)
  begin : g_bad_tick_cyc
    $error("mdpc_top: TICK_CYC out of range");
  end

  ////////////////////////////////////////////////////////////
  // Byte receiver and 10 us tick
  logic [7:0] rx_byte;
  logic rx_valid;
  logic [15:0] tick_cnt;
  wire tick = (tick_cnt == 16'h0000);

  mdpc_rx #(.BIT_CYC(BIT_CYC)) u_rx (
    .sys_clk(sys_clk),
    .rst(rst),
    .midi_in(midi_in),
    .rx_byte(rx_byte),
    .rx_valid(rx_valid)
  );

  always_ff @(posedge sys_clk)
  begin
    if (rst || tick)
      tick_cnt <= 16'(TICK_CYC - 1);
    else
      tick_cnt <= tick_cnt - 16'h0001;
  end

  ////////////////////////////////////////////////////////////
  // Message parser with running status; real-time bytes pass through
  mdpc_parse_t state;
  logic [7:0] status;
  logic [6:0] data1;
  mdpc_cc_t cc;
  logic cc_valid;
  logic msg_done;
  logic clock_tick;

  wire is_status = rx_valid && rx_byte[7];
  wire is_data = rx_valid && !rx_byte[7];
  wire is_rt = is_status && (rx_byte[7:3] == 5'h1F);
  wire is_clock = is_rt && (rx_byte[2:0] == 3'h0);
  wire is_common = is_status && !is_rt && (rx_byte[7:4] == 4'hF);
  wire st_two = (status[7:4] != 4'hC) && (status[7:4] != 4'hD);
  wire st_chan = status[7] && (status[7:4] != 4'hF);
  wire st_cc = (status[7:4] == 4'hB) && (status[3:0] == midi_chan);

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      state <= MDPC_IDLE;
      status <= 8'h00;
      data1 <= 7'h00;
      cc <= '0;
      cc_valid <= 1'b0;
      msg_done <= 1'b0;
      clock_tick <= 1'b0;
    end
    else
    begin
      cc_valid <= 1'b0;
      clock_tick <= is_clock;
      msg_done <= (is_rt && !is_clock) || is_common;
      if (is_status && !is_rt)
      begin
        status <= is_common ? 8'h00 : rx_byte;
        state <= is_common ? MDPC_IDLE : MDPC_DATA1;
      end
      else if (is_data)
      begin
        unique case (state)
          MDPC_IDLE:
          begin
            if (st_chan)
            begin
              data1 <= rx_byte[6:0];
              state <= st_two ? MDPC_DATA2 : MDPC_DATA1;
              msg_done <= !st_two;
            end
          end
          MDPC_DATA1:
          begin
            data1 <= rx_byte[6:0];
            state <= st_two ? MDPC_DATA2 : MDPC_DATA1;
            msg_done <= !st_two;
          end
          MDPC_DATA2:
          begin
            state <= MDPC_DATA1;
            msg_done <= 1'b1;
            cc <= '{num: data1, val: rx_byte[6:0]};
            cc_valid <= st_cc;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////
  // Controller decode; unassigned numbers match nothing
  wire wr_time_m = cc_valid && cc.num == `MDPC_CC_TIME_MSB;
  wire wr_time_l = cc_valid && cc.num == `MDPC_CC_TIME_LSB;
  wire wr_fb_m = cc_valid && cc.num == `MDPC_CC_FB_MSB;
  wire wr_fb_l = cc_valid && cc.num == `MDPC_CC_FB_LSB;
  wire wr_gl_m = cc_valid && cc.num == `MDPC_CC_GLIDE_MSB;
  wire wr_gl_l = cc_valid && cc.num == `MDPC_CC_GLIDE_LSB;
  wire wr_span = cc_valid && cc.num == `MDPC_CC_SPAN;
  wire wr_ext = cc_valid && cc.num == `MDPC_CC_EXTEND;
  wire wr_sync = cc_valid && cc.num == `MDPC_CC_SYNC;
  wire wr_frac = cc_valid && cc.num == `MDPC_CC_FRACTION;
  wire wr_tone = cc_valid && cc.num == `MDPC_CC_TONE;

  logic [6:0] time_msb;
  logic [6:0] fb_msb;
  logic [6:0] gl_msb;
  logic [13:0] midi_time;
  logic [13:0] midi_fb;
  logic midi_span;
  mdpc_tone_t tone;

  // Upper halves wait; the lower half commits the joined value
  wire [13:0] joined_time = {time_msb, cc.val};
  wire [13:0] joined_fb = {fb_msb, cc.val};
  wire [13:0] joined_gl = {gl_msb, cc.val};

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      time_msb <= 7'h00;
      fb_msb <= 7'h00;
      gl_msb <= 7'h00;
      midi_time <= 14'h0000;
      midi_fb <= 14'h0000;
      midi_span <= 1'b0;
      glide_speed <= `MDPC_RST_GLIDE;
      length_extender <= 7'h00;
      tempo_lock_switch <= 1'b0;
      beat_fraction <= `MDPC_RST_FRACTION;
      tone <= MDPC_TONE_AUTO;
    end
    else
    begin
      if (wr_time_m)
        time_msb <= cc.val;
      if (wr_fb_m)
        fb_msb <= cc.val;
      if (wr_gl_m)
        gl_msb <= cc.val;
      if (wr_time_l)
        midi_time <= joined_time;
      if (wr_fb_l)
        midi_fb <= joined_fb;
      if (wr_gl_l)
        glide_speed <= joined_gl;
      if (wr_span)
        midi_span <= cc.val[6];
      if (wr_ext)
        length_extender <= cc.val;
      if (wr_sync)
        tempo_lock_switch <= cc.val[6];
      // Time writes select the fraction while locked
      if (wr_frac)
        beat_fraction <= cc.val[6:4];
      else if (wr_time_l && tempo_lock_switch)
        beat_fraction <= joined_time[13:11];
      if (wr_tone)
        tone <= (cc.val >= `MDPC_TONE_BRIGHT_MIN) ? MDPC_TONE_BRIGHT :
                (cc.val >= `MDPC_TONE_DARK_MIN) ? MDPC_TONE_DARK : MDPC_TONE_AUTO;
    end
  end

  ////////////////////////////////////////////////////////////
  // Panel/MIDI ownership: last mover wins; MIDI set wins a same-cycle tie
  logic [13:0] last_time;
  logic [13:0] last_fb;
  logic last_span;
  logic own_time;
  logic own_fb;
  logic own_span;

  wire [13:0] dt = (panel_time > last_time) ? panel_time - last_time : last_time - panel_time;
  wire [13:0] df = (panel_feedback > last_fb) ? panel_feedback - last_fb
                                              : last_fb - panel_feedback;
  wire mv_time = dt > `MDPC_DEAD_BAND;
  wire mv_fb = df > `MDPC_DEAD_BAND;
  wire mv_span = panel_span_long != last_span;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      last_time <= 14'h0000;
      last_fb <= 14'h0000;
      last_span <= 1'b0;
      own_time <= 1'b0;
      own_fb <= 1'b0;
      own_span <= 1'b0;
    end
    else
    begin
      if (mv_time)
        last_time <= panel_time;
      if (mv_fb)
        last_fb <= panel_feedback;
      last_span <= panel_span_long;
      own_time <= wr_time_l || (own_time && !mv_time);
      own_fb <= wr_fb_l || (own_fb && !mv_fb);
      own_span <= wr_span || (own_span && !mv_span);
    end
  end

  wire [13:0] time_set = own_time ? midi_time : last_time;
  wire span_long = own_span ? midi_span : last_span;
  wire next_dark = (tone == MDPC_TONE_AUTO) ? span_long : (tone == MDPC_TONE_DARK);

  ////////////////////////////////////////////////////////////
  // Delay target in 10 us units
  wire [33:0] scaled = 34'(time_set) * 34'(`MDPC_SHORT_SPAN);
  wire [19:0] short_time = `MDPC_SHORT_MIN + 20'(scaled[33:14]);
  wire [19:0] span_time = span_long ? {short_time[18:0], 1'b0} : short_time;
  wire [22:0] ext_time = 23'(span_time) * 23'({1'b0, length_extender[6:5]} + 3'h1);
  wire [19:0] manual_time = ext_time[22:20] != 3'h0 ? 20'hFFFFF : ext_time[19:0];

  // MIDI clock period measured in ticks, 24 clocks per beat
  logic [15:0] period_cnt;
  logic [15:0] period;
  logic [4:0] clk_phase;
  wire beat = clock_tick && clk_phase == 5'h00;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      period_cnt <= 16'h0000;
      period <= 16'h0000;
      clk_phase <= 5'h00;
    end
    else if (clock_tick)
    begin
      period <= period_cnt;
      period_cnt <= 16'h0000;
      clk_phase <= clk_phase == `MDPC_CLOCKS_PER_BEAT ? 5'h00 : clk_phase + 5'h01;
    end
    else if (tick && period_cnt != 16'hFFFF)
      period_cnt <= period_cnt + 16'h0001;
  end

  function automatic logic [6:0] frac_clocks(input logic [2:0] sel);
    unique case (sel)
      3'h0: frac_clocks = 7'h60;
      3'h1: frac_clocks = 7'h48;
      3'h2: frac_clocks = 7'h30;
      3'h3: frac_clocks = 7'h24;
      3'h4: frac_clocks = 7'h18;
      3'h5: frac_clocks = 7'h12;
      3'h6: frac_clocks = 7'h0C;
      3'h7: frac_clocks = 7'h06;
    endcase
  endfunction

  wire [22:0] sync_full = 23'(period) * 23'(frac_clocks(beat_fraction));
  wire [19:0] sync_time = sync_full[22:20] != 3'h0 ? 20'hFFFFF : sync_full[19:0];
  wire [19:0] target = tempo_lock_switch ? sync_time : manual_time;
  wire [19:0] step = {6'h00, glide_speed} + 20'h00001;
  wire [19:0] gap = (target > delay_time) ? target - delay_time : delay_time - target;
  wire [19:0] next_delay = gap <= step ? target :
                           (target > delay_time) ? delay_time + step : delay_time - step;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      feedback <= 14'h0000;
      span_select <= 1'b0;
      tone_dark <= 1'b0;
      delay_time <= `MDPC_SHORT_MIN;
      time_illegal <= 1'b0;
    end
    else
    begin
      feedback <= own_fb ? midi_fb : last_fb;
      span_select <= span_long;
      tone_dark <= next_dark;
      time_illegal <= !tempo_lock_switch && length_extender[6:5] != 2'h0 &&
                      manual_time > {span_time[18:0], 1'b0};
      if (tick)
        delay_time <= next_delay;
    end
  end

  ////////////////////////////////////////////////////////////
  // Lamps
  logic [19:0] rate_cnt;
  wire time_beat = tick && rate_cnt >= delay_time;

  always_ff @(posedge sys_clk)
  begin
    if (rst || time_beat)
      rate_cnt <= 20'h00000;
    else if (tick)
      rate_cnt <= rate_cnt + 20'h00001;
  end

  logic [5:0] flash;
  logic [5:0] fire;
  logic tap_time_q;
  logic tap_rate_q;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      tap_time_q <= 1'b0;
      tap_rate_q <= 1'b0;
    end
    else
    begin
      tap_time_q <= tap_to_time;
      tap_rate_q <= tap_to_rate;
    end
  end

  assign fire[0] = time_beat && !tempo_lock_switch && !tap_to_time;
  assign fire[1] = (tap_to_time && !tap_time_q) || (tap_beat && tap_to_time);
  assign fire[2] = beat;
  assign fire[3] = (tap_to_rate && !tap_rate_q) || (tap_beat && tap_to_rate);
  assign fire[4] = limit_start;
  assign fire[5] = msg_done;

  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++)
    begin : g_flash
      mdpc_flash #(.LEN(FLASH_TICKS)) u_flash (
        .sys_clk(sys_clk),
        .rst(rst),
        .tick(tick),
        .trigger(fire[gi]),
        .lit(flash[gi])
      );
    end
  endgenerate

  wire lock_lit = flash[2] && tempo_lock_switch;
  wire mod_lock_lit = flash[2] && mod_sync;
  wire mod_red = mod_wave_level && !mod_sync && !tap_to_rate;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      echo_length_lamp <= '0;
      modulator_lamp <= '0;
      signal_meter_lamp <= '0;
      message_lamp <= 1'b0;
      engage_switch_lamp <= 1'b0;
    end
    else
    begin
      echo_length_lamp <= '{red: flash[0] || lock_lit, green: flash[1] || lock_lit};
      modulator_lamp <= '{red: mod_red || mod_lock_lit,
                          green: flash[3] || mod_lock_lit};
      signal_meter_lamp <= '{red: clipping || flash[4],
                             green: !clipping && (sig_present || flash[4])};
      message_lamp <= flash[5];
      engage_switch_lamp <= engaged;
    end
  end

endmodule

// [rtl/mdpc_defs.svh]
// Timing counts, controller numbers and reset values of the delay control block.
// Assumes a 100 MHz system clock and a MIDI link at its standard bit rate.
`ifndef MDPC_DEFS_SVH
`define MDPC_DEFS_SVH

`define MDPC_CLK_NS 10
`define MDPC_BAUD 31250
`define MDPC_BIT_CYC (1000000000 / (`MDPC_CLK_NS * `MDPC_BAUD))
`define MDPC_TICK_NS 10000
`define MDPC_TICK_CYC (`MDPC_TICK_NS / `MDPC_CLK_NS)
`define MDPC_FLASH_MS 50
`define MDPC_FLASH_TICKS (`MDPC_FLASH_MS * 1000000 / `MDPC_TICK_NS)

`define MDPC_CC_TIME_MSB 7'h0C
`define MDPC_CC_TIME_LSB 7'h2C
`define MDPC_CC_FB_MSB 7'h0D
`define MDPC_CC_FB_LSB 7'h2D
`define MDPC_CC_GLIDE_MSB 7'h05
`define MDPC_CC_GLIDE_LSB 7'h25
`define MDPC_CC_SPAN 7'h4A
`define MDPC_CC_EXTEND 7'h4B
`define MDPC_CC_SYNC 7'h4C
`define MDPC_CC_FRACTION 7'h4D
`define MDPC_CC_TONE 7'h59

`define MDPC_SHORT_MIN 20'h00DAC
`define MDPC_SHORT_SPAN 20'h08E94
`define MDPC_DEAD_BAND 14'h0040
`define MDPC_TONE_DARK_MIN 7'h2B
`define MDPC_TONE_BRIGHT_MIN 7'h56
`define MDPC_CLOCKS_PER_BEAT 5'h17
`define MDPC_RST_FRACTION 3'h4
`define MDPC_RST_GLIDE 14'h3FFF

`endif

// [rtl/mdpc_pkg.sv]
// Types shared by the delay control block.
// Constants live in mdpc_defs.svh.
package mdpc_pkg;

  typedef enum logic [1:0] {MDPC_IDLE, MDPC_DATA1, MDPC_DATA2} mdpc_parse_t;

  typedef enum logic [1:0] {MDPC_TONE_AUTO, MDPC_TONE_DARK, MDPC_TONE_BRIGHT} mdpc_tone_t;

  typedef struct packed {
    logic red;
    logic green;
  } mdpc_lamp_t;

  typedef struct packed {
    logic [6:0] num;
    logic [6:0] val;
  } mdpc_cc_t;

endpackage

// [rtl/mdpc_rx.sv]
// Serial MIDI byte receiver: 8 data bits, one stop bit, idle high.
// Assumes the serial pin is asynchronous to sys_clk.
`timescale 1ns/1ps
`include "mdpc_defs.svh"

module mdpc_rx
  import mdpc_pkg::*;
#(
  parameter int BIT_CYC = `MDPC_BIT_CYC
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic midi_in,
  output logic [7:0] rx_byte,
  output logic rx_valid
);

  if (BIT_CYC < 4 || BIT_CYC > 65535)
  begin : g_bad_bit_cyc
    $error("mdpc_rx: BIT_CYC out of range");
  end

  logic [2:0] sync;
  logic line;
  logic busy;
  logic [15:0] cnt;
  logic [3:0] bitn;
  logic [8:0] shift;

  wire agree = (sync[1] == sync[2]);
  wire cnt_done = (cnt == 16'h0000);
  wire start_seen = !busy && !line;

  ////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      sync <= 3'h7;
      line <= 1'b1;
    end
    else
    begin
      sync <= {sync[1:0], midi_in};
      if (agree)
        line <= sync[2];
    end
  end

  // Sample in mid-bit: half a bit after the start edge, then whole bits
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      busy <= 1'b0;
      cnt <= 16'h0000;
      bitn <= 4'h0;
      shift <= 9'h000;
      rx_byte <= 8'h00;
      rx_valid <= 1'b0;
    end
    else
    begin
      rx_valid <= 1'b0;
      if (start_seen)
      begin
        busy <= 1'b1;
        cnt <= 16'(BIT_CYC / 2);
        bitn <= 4'h0;
      end
      else if (busy && cnt_done)
      begin
        cnt <= 16'(BIT_CYC - 1);
        bitn <= bitn + 4'h1;
        shift <= {line, shift[8:1]};
        if (bitn == 4'h0 && line)
          busy <= 1'b0;
        else if (bitn == 4'h9)
        begin
          busy <= 1'b0;
          rx_byte <= shift[8:1];
          rx_valid <= line;
        end
      end
      else if (busy)
        cnt <= cnt - 16'h0001;
    end
  end

endmodule

// [rtl/mdpc_flash.sv]
// One-shot lamp flash: holds its output for LEN ticks after a trigger.
// Assumes trigger and tick come from logic on sys_clk.
`timescale 1ns/1ps
`include "mdpc_defs.svh"

module mdpc_flash
  import mdpc_pkg::*;
#(
  parameter int LEN = `MDPC_FLASH_TICKS
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic tick,
  input wire logic trigger,
  output logic lit
);

  if (LEN < 1 || LEN > 65535)
  begin : g_bad_len
    $error("mdpc_flash: LEN out of range");
  end

  logic [15:0] left;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      left <= 16'h0000;
      lit <= 1'b0;
    end
    else
    begin
      if (trigger)
        left <= 16'(LEN);
      else if (tick && left != 16'h0000)
        left <= left - 16'h0001;
      lit <= trigger || (left != 16'h0000);
    end
  end

endmodule

// [verification/mdpc_top_monitor.sv]
// Checker for the delay control block: lamp and glide relations at the top ports.
// Assumes it is bound into mdpc_top and sees only its ports.
`timescale 1ns/1ps
module mdpc_top_monitor
  import mdpc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic tap_to_time,
  input wire logic tap_to_rate,
  input wire logic mod_wave_level,
  input wire logic mod_sync,
  input wire logic limit_start,
  input wire logic clipping,
  input wire logic engaged,
  input wire logic tempo_lock_switch,
  input wire logic span_select,
  input wire logic [13:0] glide_speed,
  input wire logic [19:0] delay_time,
  input wire mdpc_lamp_t echo_length_lamp,
  input wire mdpc_lamp_t modulator_lamp,
  input wire mdpc_lamp_t signal_meter_lamp,
  input wire logic message_lamp,
  input wire logic engage_switch_lamp
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic [19:0] prev_time;
  logic [19:0] step;
  always_ff @(posedge sys_clk)
  begin
    prev_time <= delay_time;
  end
  assign step = (delay_time > prev_time) ? delay_time - prev_time : prev_time - delay_time;
  ////////////////////////////////////////////////////////////////////////////////
  a_engage_lamp_on: assert property (engaged [*2] |-> engage_switch_lamp)
    else $error("engage lamp dark while engaged");
  a_engage_lamp_off: assert property (!engaged [*2] |-> !engage_switch_lamp)
    else $error("engage lamp lit while bypassed");
  a_meter_clip_red: assert property (clipping |-> ##[1:2] signal_meter_lamp.red)
    else $error("meter not red on clipping");
  a_meter_limit_orange: assert property (limit_start && !clipping |->
    ##[1:2] (signal_meter_lamp.red && signal_meter_lamp.green))
    else $error("meter not orange on limiting");
  a_echo_tap_green: assert property ($rose(tap_to_time) && !tempo_lock_switch |->
    ##[1:2] echo_length_lamp.green)
    else $error("echo lamp missed green flash");
  a_mod_tap_green: assert property ($rose(tap_to_rate) && !mod_sync |->
    ##[1:2] modulator_lamp.green)
    else $error("modulator lamp missed green flash");
  a_mod_wave_red: assert property ((mod_wave_level && !mod_sync && !tap_to_rate) [*2] |->
    modulator_lamp.red)
    else $error("modulator lamp not red with waveform on");
  // Step bound only; a glide change in the same cycle is left out
  a_glide_step_bound: assert property (!$stable(delay_time) && $stable(glide_speed) |->
    step <= {6'h00, glide_speed} + 20'h00001)
    else $error("delay time jumped more than one glide step");
  c_message: cover property ($rose(message_lamp));
  c_lock: cover property ($rose(tempo_lock_switch));
  c_span: cover property ($rose(span_select));
endmodule

bind mdpc_top mdpc_top_monitor u_mon (.sys_clk, .rst, .tap_to_time, .tap_to_rate,
  .mod_wave_level, .mod_sync, .limit_start, .clipping, .engaged, .tempo_lock_switch,
  .span_select, .glide_speed, .delay_time, .echo_length_lamp, .modulator_lamp,
  .signal_meter_lamp, .message_lamp, .engage_switch_lamp);

// [verification/mdpc_midi_host.sv]
// MIDI sender model: serial line, idle high, one frame per send_byte call.
// Assumes sys_clk is the design clock; bit length is BIT_CYC cycles.
`timescale 1ns/1ps
module mdpc_midi_host
#(
  parameter int BIT_CYC = 16
)
(
  input wire logic sys_clk,
  output logic midi_line
);
  initial midi_line = 1'b1;
  // Start low, data lowest bit first, stop high; gap adds idle after the frame
  task automatic send_byte(input logic [7:0] b, input int gap);
    logic [9:0] frame;
    frame = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      @(posedge sys_clk);
      #1;
      midi_line = frame[i];
      repeat (BIT_CYC - 1) @(posedge sys_clk);
    end
    repeat (gap) @(posedge sys_clk);
  endtask
endmodule

// [verification/tb.sv]
// Self-checking bench for mdpc_top with short bit, tick and flash counts.
// Assumes the MIDI host model drives midi_in; channel 0 is the accepted one.
`timescale 1ns/1ps
module tb
  import mdpc_pkg::*;
;
  typedef struct packed {
    mdpc_cc_t cc;
    logic [2:0] sel;
    logic [19:0] exp;
  } mdpc_row_t;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  wire midi_in;
  logic [3:0] midi_chan = 4'h0;
  logic [13:0] panel_time = 14'h0000;
  logic [13:0] panel_feedback = 14'h0000;
  logic panel_span_long = 1'b0, tap_to_time = 1'b0, tap_to_rate = 1'b0, tap_beat = 1'b0;
  logic mod_wave_level = 1'b0, mod_sync = 1'b0, sig_present = 1'b0, limit_start = 1'b0;
  logic clipping = 1'b0, engaged = 1'b0;
  logic tempo_lock_switch, span_select, tone_dark, time_illegal, message_lamp;
  logic engage_switch_lamp;
  logic [13:0] feedback, glide_speed;
  logic [6:0] length_extender;
  logic [2:0] beat_fraction;
  logic [19:0] delay_time;
  mdpc_lamp_t echo_length_lamp, modulator_lamp, signal_meter_lamp;
  int n_mismatch = 0;
  int num_checks = 0;
  logic seen;
  mdpc_row_t rows [19] = '{
    '{'{7'h4A, 7'h40}, 3'h1, 20'h1}, '{'{7'h14, 7'h33}, 3'h6, 20'h1},
    '{'{7'h59, 7'h56}, 3'h6, 20'h0}, '{'{7'h59, 7'h2B}, 3'h6, 20'h1},
    '{'{7'h59, 7'h00}, 3'h6, 20'h1}, '{'{7'h4A, 7'h00}, 3'h6, 20'h0},
    '{'{7'h4B, 7'h60}, 3'h4, 20'h60}, '{'{7'h4B, 7'h00}, 3'h4, 20'h0},
    '{'{7'h4D, 7'h70}, 3'h5, 20'h7}, '{'{7'h4C, 7'h7F}, 3'h0, 20'h1},
    '{'{7'h0C, 7'h20}, 3'h5, 20'h7}, '{'{7'h2C, 7'h00}, 3'h5, 20'h2},
    '{'{7'h4C, 7'h00}, 3'h0, 20'h0}, '{'{7'h0D, 7'h10}, 3'h2, 20'h0},
    '{'{7'h2D, 7'h05}, 3'h2, 20'h805}, '{'{7'h2D, 7'h06}, 3'h2, 20'h806},
    '{'{7'h05, 7'h01}, 3'h3, 20'h3FFF}, '{'{7'h25, 7'h02}, 3'h3, 20'h82},
    '{'{7'h14, 7'h33}, 3'h3, 20'h82}
  };

  always #5 sys_clk = ~sys_clk;

  mdpc_top #(.BIT_CYC(16), .TICK_CYC(4), .FLASH_TICKS(3)) DUT (.sys_clk, .rst, .midi_in,
    .midi_chan, .panel_time, .panel_feedback, .panel_span_long, .tap_to_time, .tap_to_rate,
    .tap_beat, .mod_wave_level, .mod_sync, .sig_present, .limit_start, .clipping, .engaged,
    .tempo_lock_switch, .span_select, .feedback, .glide_speed, .length_extender,
    .beat_fraction, .tone_dark, .delay_time, .time_illegal, .echo_length_lamp,
    .modulator_lamp, .signal_meter_lamp, .message_lamp, .engage_switch_lamp);
  mdpc_midi_host #(.BIT_CYC(16)) host (.sys_clk(sys_clk), .midi_line(midi_in));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    if (n_mismatch == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic check(input logic [19:0] got, input logic [19:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  function automatic logic [19:0] pick(input logic [2:0] sel);
    case (sel)
      3'h0: pick = {19'h0, tempo_lock_switch};
      3'h1: pick = {19'h0, span_select};
      3'h2: pick = {6'h0, feedback};
      3'h3: pick = {6'h0, glide_speed};
      3'h4: pick = {13'h0, length_extender};
      3'h5: pick = {17'h0, beat_fraction};
      3'h6: pick = {19'h0, tone_dark};
      default: pick = delay_time;
    endcase
  endfunction

  task automatic send_cc(input logic [6:0] num, input logic [6:0] val);
    host.send_byte(8'hB0, 2);
    host.send_byte({1'b0, num}, 0);
    host.send_byte({1'b0, val}, 0);
    step(30);
  endtask

  task automatic wait_val(input logic [2:0] sel, input logic [19:0] exp, input int bound);
    int n;
    n = 0;
    while (pick(sel) !== exp && n < bound)
    begin
      step(1);
      n++;
    end
    check(pick(sel), exp);
    if (n >= bound)
      tally_and_finish();
  endtask

  task automatic reset_check();
    check({tempo_lock_switch, span_select, tone_dark, time_illegal, message_lamp}, 20'h0);
    check({feedback, beat_fraction}, {14'h0000, 3'h4});
    check(glide_speed, 20'h3FFF);
    check(delay_time, 20'h00DAC);
    check({echo_length_lamp, modulator_lamp, signal_meter_lamp}, 20'h0);
  endtask

  task automatic watch_lamp(input int n);
    seen = 1'b0;
    repeat (n)
    begin
      step(1);
      seen = seen | message_lamp;
    end
  endtask

  initial
  begin
    step(3);
    rst = 1'b0;
    reset_check();
    foreach (rows[i])
    begin
      send_cc(rows[i].cc.num, rows[i].cc.val);
      check(pick(rows[i].sel), rows[i].exp);
    end
    // Foreign channel and a note message must both be dropped
    host.send_byte(8'hB1, 0);
    host.send_byte(8'h4A, 0);
    host.send_byte(8'h40, 0);
    host.send_byte(8'h90, 0);
    host.send_byte(8'h4A, 0);
    host.send_byte(8'h40, 0);
    step(40);
    check(span_select, 20'h0);
    host.send_byte(8'hF8, 0);
    watch_lamp(40);
    check(seen, 20'h0);
    host.send_byte(8'hFE, 0);
    watch_lamp(40);
    check(seen, 20'h1);
    // Running status: second message carries no status byte
    host.send_byte(8'hB0, 0);
    host.send_byte(8'h0C, 0);
    host.send_byte(8'h7F, 0);
    host.send_byte(8'h2C, 0);
    host.send_byte(8'h7F, 0);
    wait_val(3'h7, 20'h09C3D, 3000);
    check(beat_fraction, 20'h2);
    send_cc(7'h4A, 7'h40);
    wait_val(3'h7, 20'h1387A, 3000);
    send_cc(7'h4B, 7'h20);
    wait_val(3'h7, 20'h270F4, 4000);
    send_cc(7'h4B, 7'h40);
    check(time_illegal, 20'h1);
    panel_feedback = 14'h1000;
    wait_val(3'h2, 20'h1000, 10);
    send_cc(7'h2D, 7'h07);
    check(feedback, 20'h0807);
    panel_feedback = 14'h1020;
    step(10);
    check(feedback, 20'h0807);
    send_cc(7'h4A, 7'h00);
    check(span_select, 20'h0);
    engaged = 1'b1;
    tap_to_time = 1'b1;
    tap_to_rate = 1'b1;
    clipping = 1'b1;
    step(4);
    check(engage_switch_lamp, 20'h1);
    clipping = 1'b0;
    tap_to_rate = 1'b0;
    mod_wave_level = 1'b1;
    limit_start = 1'b1;
    tap_beat = 1'b1;
    step(1);
    limit_start = 1'b0;
    tap_beat = 1'b0;
    sig_present = 1'b1;
    step(6);
    engaged = 1'b0;
    mod_sync = 1'b1;
    panel_span_long = 1'b1;
    step(6);
    check(span_select, 20'h1);
    rst = 1'b1;
    step(3);
    rst = 1'b0;
    mod_sync = 1'b0;
    reset_check();
    tally_and_finish();
  end
endmodule
